// *** hw/stop_seq_pkg.sv ***
// Constants and types for the stop-sequence selection block
package stop_seq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DRIVE_INHIBIT = 8'h00;
  localparam logic [7:0] OFS_SERVO_OFF = 8'h04;
  localparam logic [7:0] OFS_MAINS_OFF = 8'h08;
  localparam logic [7:0] OFS_UV_ACTION = 8'h0c;
  localparam logic [7:0] OFS_HOLD_TIME = 8'h10;
  localparam logic [7:0] OFS_ALARM_STOP = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Reset values and legal minima and maxima
  localparam logic [1:0] DRIVE_INHIBIT_RST = 2'h0;
  localparam logic [1:0] DRIVE_INHIBIT_MAX = 2'h2;
  localparam logic [3:0] SERVO_OFF_RST = 4'h0;
  localparam logic [3:0] STOP_SEL_MAX = 4'h9;
  localparam logic [2:0] ALARM_STOP_RST = 3'h0;
  localparam logic UV_ACTION_RST = 1'b1;
  localparam logic [10:0] HOLD_TIME_RST = 11'h046;
  localparam logic [10:0] HOLD_TIME_MIN = 11'h046;
  localparam logic [10:0] HOLD_TIME_MAX = 11'h7d0;
  // Hold time unit, 1 ms, in ns and in 100 MHz cycles
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int HOLD_UNIT_NS = 1000000;
  localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_NS / CLOCK_PERIOD_NS;
  // Braking actions toward the power stage
  typedef enum logic [1:0] {BRAKE_NONE, BRAKE_DYN, BRAKE_FREE, BRAKE_ESTOP} brake_t;
endpackage

// *** hw/stop_seq_select.sv ***
// Stop-sequence selection with an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module stop_seq_select
  import stop_seq_pkg::*;
#(
  // Clocks per 1 ms step of the hold time; only simulation shortens it
  parameter int UNIT_CYCLES = HOLD_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host control pins (asynchronous)
  input wire logic fwd_prohibit_in,
  input wire logic rev_prohibit_in,
  input wire logic servo_on_in,
  input wire logic mains_present_in,
  input wire logic alarm_in,
  input wire logic alarm_estop_in,
  input wire logic motor_stopped_in,
  // Power stage controls
  output logic fwd_torque_off,
  output logic rev_torque_off,
  output stop_seq_pkg::brake_t brake_action,
  output logic error_counter_clear,
  output logic undervoltage_trip,
  output logic mains_alarm
);
  import stop_seq_pkg::*;

  // Active settings and pending power-up settings
  logic [1:0] drive_inhibit_reg;
  logic [1:0] drive_inhibit_pend_reg;
  logic [3:0] servo_off_reg;
  logic [3:0] mains_off_reg;
  logic uv_action_reg;
  logic [10:0] hold_time_reg;
  logic [10:0] hold_time_pend_reg;
  logic [2:0] alarm_stop_reg;
  logic powerup_req;

  // Two-flop synchronisers for the pins
  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
    end else begin
      pin_meta_reg <= {motor_stopped_in, alarm_estop_in, alarm_in, mains_present_in,
                       servo_on_in, rev_prohibit_in, fwd_prohibit_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  logic fwd_proh, rev_proh, servo_on, mains_ok, alarm, alarm_estop, stopped;
  assign {stopped, alarm_estop, alarm, mains_ok, servo_on, rev_proh, fwd_proh} = pin_sync_reg;

  // AXI write channel: address and data taken in either order
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= OFS_STATUS) ? 2'h0 : 2'h3;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Register writes; illegal values are dropped without changing anything
  logic [31:0] wv;
  assign wv = w_data_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drive_inhibit_pend_reg <= DRIVE_INHIBIT_RST;
      servo_off_reg <= SERVO_OFF_RST;
      mains_off_reg <= SERVO_OFF_RST;
      uv_action_reg <= UV_ACTION_RST;
      hold_time_pend_reg <= HOLD_TIME_RST;
      alarm_stop_reg <= ALARM_STOP_RST;
    end else if (wr_fire && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        OFS_DRIVE_INHIBIT: if (wv <= 32'(DRIVE_INHIBIT_MAX)) drive_inhibit_pend_reg <= wv[1:0];
        OFS_SERVO_OFF: if (wv <= 32'(STOP_SEL_MAX)) servo_off_reg <= wv[3:0];
        OFS_MAINS_OFF: if (wv <= 32'(STOP_SEL_MAX)) mains_off_reg <= wv[3:0];
        OFS_UV_ACTION: if (wv <= 32'h1) uv_action_reg <= wv[0];
        OFS_HOLD_TIME:
          if (w_strb_reg[1] && wv >= 32'(HOLD_TIME_MIN) && wv <= 32'(HOLD_TIME_MAX)) begin
            hold_time_pend_reg <= wv[10:0];
          end
        OFS_ALARM_STOP: if (wv <= 32'h7) alarm_stop_reg <= wv[2:0];
        default: ;
      endcase
    end
  end

  // Power-up settings load on reset release or a control write of bit 0
  assign powerup_req = wr_fire && aw_addr_reg == OFS_CONTROL && w_strb_reg[0] && wv[0];
  logic booted_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      booted_reg <= 1'b0;
      drive_inhibit_reg <= DRIVE_INHIBIT_RST;
      hold_time_reg <= HOLD_TIME_RST;
    end else begin
      booted_reg <= 1'b1;
      if (!booted_reg || powerup_req) begin
        drive_inhibit_reg <= drive_inhibit_pend_reg;
        hold_time_reg <= hold_time_pend_reg;
      end
    end
  end

  // Mains-loss timer: 1 ms prescaler plus ms counter
  logic [16:0] us_cnt_reg;
  logic [10:0] ms_cnt_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      us_cnt_reg <= 17'h0;
      ms_cnt_reg <= 11'h0;
      mains_alarm <= 1'b0;
    end else if (mains_ok) begin
      us_cnt_reg <= 17'h0;
      ms_cnt_reg <= 11'h0;
      mains_alarm <= 1'b0;
    end else if (!mains_alarm) begin
      if (us_cnt_reg == 17'(UNIT_CYCLES - 1)) begin
        us_cnt_reg <= 17'h0;
        ms_cnt_reg <= ms_cnt_reg + 11'h1;
        if (ms_cnt_reg + 11'h1 >= hold_time_reg) mains_alarm <= 1'b1;
      end else begin
        us_cnt_reg <= us_cnt_reg + 17'h1;
      end
    end
  end

  // Decode of the 0..9 stop selections shared by servo-off and mains-off
  function automatic brake_t sel_brake(input logic [3:0] sel, input logic stop_done);
    if (sel >= 4'h8) begin
      sel_brake = stop_done ? (sel[0] ? BRAKE_FREE : BRAKE_DYN) : BRAKE_ESTOP;
    end else if (stop_done) begin
      sel_brake = sel[1] ? BRAKE_FREE : BRAKE_DYN;
    end else begin
      sel_brake = sel[0] ? BRAKE_FREE : BRAKE_DYN;
    end
  endfunction

  // Stop source priority: alarm, mains, servo off, prohibit
  logic uv_event;
  brake_t brake_next;
  logic clear_next;
  assign uv_event = mains_alarm && uv_action_reg;
  always_comb begin
    brake_next = BRAKE_NONE;
    clear_next = 1'b0;
    if (alarm || uv_event) begin
      if (alarm && alarm_estop && alarm_stop_reg[2] && !stopped) brake_next = BRAKE_ESTOP;
      else brake_next = sel_brake({2'h0, alarm_stop_reg[1:0]}, stopped);
      clear_next = 1'b1;
    end else if (mains_alarm) begin
      brake_next = sel_brake(mains_off_reg, stopped);
      clear_next = !(mains_off_reg inside {[4'h4:4'h7]});
    end else if (!servo_on) begin
      brake_next = sel_brake(servo_off_reg, stopped);
      clear_next = !(servo_off_reg inside {[4'h4:4'h7]});
    end else if (fwd_proh || rev_proh) begin
      unique case (drive_inhibit_reg)
        2'h1: brake_next = BRAKE_FREE;
        2'h2: brake_next = BRAKE_ESTOP;
        default: brake_next = BRAKE_DYN;
      endcase
    end
  end

  // Registered stage outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      brake_action <= BRAKE_NONE;
      error_counter_clear <= 1'b0;
      undervoltage_trip <= 1'b0;
      fwd_torque_off <= 1'b0;
      rev_torque_off <= 1'b0;
    end else begin
      brake_action <= brake_next;
      error_counter_clear <= clear_next;
      undervoltage_trip <= uv_event;
      fwd_torque_off <= fwd_proh;
      rev_torque_off <= rev_proh;
    end
  end

  // AXI read channel, one-cycle answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          OFS_DRIVE_INHIBIT: s_axi_rdata <= {30'h0, drive_inhibit_pend_reg};
          OFS_SERVO_OFF: s_axi_rdata <= {28'h0, servo_off_reg};
          OFS_MAINS_OFF: s_axi_rdata <= {28'h0, mains_off_reg};
          OFS_UV_ACTION: s_axi_rdata <= {31'h0, uv_action_reg};
          OFS_HOLD_TIME: s_axi_rdata <= {21'h0, hold_time_pend_reg};
          OFS_ALARM_STOP: s_axi_rdata <= {29'h0, alarm_stop_reg};
          OFS_CONTROL: s_axi_rdata <= {19'h0, hold_time_reg, drive_inhibit_reg};
          OFS_STATUS: s_axi_rdata <= {25'h0, brake_action, error_counter_clear, undervoltage_trip,
                                      mains_alarm, rev_torque_off, fwd_torque_off};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  chk_inhibit_estop: assert property (@(posedge clock) disable iff (!reset_n)
    (servo_on && !alarm && !mains_alarm && (fwd_proh || rev_proh) && drive_inhibit_reg == 2'h2)
    |=> brake_action == BRAKE_ESTOP) else $error("prohibit estop missing");
  chk_inhibit_dyn: assert property (@(posedge clock) disable iff (!reset_n)
    (servo_on && !alarm && !mains_alarm && fwd_proh && drive_inhibit_reg == 2'h0)
    |=> brake_action == BRAKE_DYN && fwd_torque_off) else $error("prohibit brake wrong");
  chk_inhibit_free: assert property (@(posedge clock) disable iff (!reset_n)
    (servo_on && !alarm && !mains_alarm && rev_proh && drive_inhibit_reg == 2'h1)
    |=> brake_action == BRAKE_FREE) else $error("prohibit free-run wrong");
  chk_servo_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (!servo_on && !alarm && !mains_alarm && servo_off_reg inside {[4'h4:4'h7]})
    |=> !error_counter_clear) else $error("counter not held");
  chk_servo_estop: assert property (@(posedge clock) disable iff (!reset_n)
    (!servo_on && !alarm && !mains_alarm && servo_off_reg >= 4'h8 && !stopped)
    |=> brake_action == BRAKE_ESTOP && error_counter_clear) else $error("servo-off estop wrong");
  chk_servo_after: assert property (@(posedge clock) disable iff (!reset_n)
    (!servo_on && !alarm && !mains_alarm && servo_off_reg == 4'h2 && stopped)
    |=> brake_action == BRAKE_FREE && error_counter_clear) else $error("servo-off after-stop wrong");
  chk_uv_trip: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(mains_alarm) && uv_action_reg |=> undervoltage_trip) else $error("trip not raised");
  chk_alarm_late: assert property (@(posedge clock) disable iff (!reset_n)
    mains_ok |=> !mains_alarm) else $error("mains alarm while powered");
  chk_alarm_estop: assert property (@(posedge clock) disable iff (!reset_n)
    (alarm && alarm_estop && alarm_stop_reg[2] && !stopped) |=> brake_action == BRAKE_ESTOP)
    else $error("alarm estop missing");
  chk_range_keep: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_fire && aw_addr_reg == OFS_SERVO_OFF && wv > 32'h9) |=> $stable(servo_off_reg))
    else $error("illegal value stored");
  chk_pend_only: assert property (@(posedge clock) disable iff (!reset_n)
    (booted_reg && !powerup_req) |=> $stable(drive_inhibit_reg)) else $error("setting live early");
endmodule
`default_nettype wire

// *** verif/power_stage_model.sv ***
// Behavioural model of the motor and power stage: coasts to standstill while braked
`timescale 1ns/100ps
`default_nettype none
module power_stage_model
  import stop_seq_pkg::*;
#(
  parameter int SLOW_CYCLES = 40,
  parameter int QUICK_CYCLES = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Stage control
  input wire logic quick,
  input wire stop_seq_pkg::brake_t brake_action,
  // Motor feedback
  output logic motor_stopped_in
);
  int cnt;

  // Standstill only after a braking action has lasted long enough; running again once released
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      motor_stopped_in <= 1'b0;
    end else if (brake_action == BRAKE_NONE) begin
      cnt <= 0;
      motor_stopped_in <= 1'b0;
    end else if (cnt >= (quick ? QUICK_CYCLES : SLOW_CYCLES)) begin
      motor_stopped_in <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_stop_seq_select.sv ***
// Self-checking testbench for the stop-sequence selection block
`timescale 1ns/100ps
`default_nettype none
module tb_stop_seq_select;
  import stop_seq_pkg::*;
  logic clock, reset_n, quick;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic fwd_prohibit_in, rev_prohibit_in, servo_on_in, mains_present_in, alarm_in, alarm_estop_in;
  logic motor_stopped_in, fwd_torque_off, rev_torque_off, error_counter_clear, undervoltage_trip, mains_alarm;
  brake_t brake_action, old_b;
  int fail_count, total_checks, i, e;
  logic [31:0] rst_tab [6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h46, 32'h0};
  logic [7:0] bad_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h10, 8'h14};
  logic [31:0] bad_v [7] = '{32'h3, 32'ha, 32'ha, 32'h2, 32'h45, 32'h7d1, 32'h8};
  brake_t pro_tab [3] = '{BRAKE_DYN, BRAKE_FREE, BRAKE_ESTOP};

  // Short 1 ms step so a 70-step mains loss fits the run: 70 x 20 = 1400 clocks
  localparam int TB_UNIT = 20;

  stop_seq_select #(.UNIT_CYCLES(TB_UNIT)) uut (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fwd_prohibit_in, .rev_prohibit_in, .servo_on_in, .mains_present_in, .alarm_in, .alarm_estop_in,
    .motor_stopped_in, .fwd_torque_off, .rev_torque_off, .brake_action, .error_counter_clear,
    .undervoltage_trip, .mains_alarm);
  power_stage_model stage (.clock, .reset_n, .quick, .brake_action, .motor_stopped_in);

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Write with both channels offered together; bready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) begin
      fail_count++;
      stop_test();
    end
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) begin
      fail_count++;
      stop_test();
    end
    d = s_axi_rdata;
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  function automatic brake_t dec_of(input logic [3:0] v, input logic es);
    return (v >= 4'h8 || es) ? BRAKE_ESTOP : (v[0] ? BRAKE_FREE : BRAKE_DYN);
  endfunction

  function automatic brake_t aft_of(input logic [3:0] v);
    return ((v >= 4'h8) ? v[0] : v[1]) ? BRAKE_FREE : BRAKE_DYN;
  endfunction

  // Braking while slowing, then after standstill; outputs settle a few clocks after a pin change
  task automatic stop_run(input brake_t dec, input brake_t aft, input logic clr);
    int n;
    cyc(6);
    check({30'h0, brake_action}, {30'h0, dec});
    check({31'h0, error_counter_clear}, {31'h0, clr});
    for (n = 0; n < 200 && motor_stopped_in !== 1'b1; n++) @(posedge clock);
    if (n == 200) begin
      fail_count++;
      stop_test();
    end
    cyc(6);
    check({30'h0, brake_action}, {30'h0, aft});
  endtask

  // One direction prohibited: torque off there only, plus the chosen stop
  task automatic prohibit(input logic f, input brake_t exp);
    @(posedge clock);
    fwd_prohibit_in <= f;
    rev_prohibit_in <= !f;
    cyc(6);
    check({31'h0, fwd_torque_off}, {31'h0, f});
    check({31'h0, rev_torque_off}, {31'h0, !f});
    check({30'h0, brake_action}, {30'h0, exp});
    fwd_prohibit_in <= 1'b0;
    rev_prohibit_in <= 1'b0;
    cyc(8);
  endtask

  initial begin
    repeat (50000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fwd_prohibit_in, rev_prohibit_in, alarm_in, alarm_estop_in, quick} = '0;
    s_axi_wstrb = 4'hf;
    servo_on_in = 1'b1;
    mains_present_in = 1'b1;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      axi_rd(8'(4 * i), rd, 2'h0);
      check(rd, rst_tab[i]);
    end
    axi_rd(OFS_CONTROL, rd, 2'h0);
    check(rd, 32'h118);
    axi_rd(8'h20, rd, 2'h3);
    axi_wr(8'h20, 32'h1, 2'h3);
    axi_wr(8'h02, 32'h1, 2'h3);
    $display("test reset and refusals done");
    for (i = 0; i < 7; i++) begin
      axi_wr(bad_a[i], bad_v[i], 2'h0);
      axi_rd(bad_a[i], rd, 2'h0);
      check(rd, rst_tab[bad_a[i][4:2]]);
    end
    // Write with no byte lanes enabled leaves the setting alone
    s_axi_wstrb <= 4'h0;
    axi_wr(OFS_SERVO_OFF, 32'h5, 2'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(OFS_SERVO_OFF, rd, 2'h0);
    check(rd, 32'h0);
    axi_wr(OFS_HOLD_TIME, 32'h7d0, 2'h0);
    axi_rd(OFS_CONTROL, rd, 2'h0);
    check(rd, 32'h118);
    axi_wr(OFS_CONTROL, 32'h1, 2'h0);
    axi_rd(OFS_CONTROL, rd, 2'h0);
    check(rd, 32'h1f40);
    axi_wr(OFS_HOLD_TIME, 32'h46, 2'h0);
    axi_wr(OFS_CONTROL, 32'h1, 2'h0);
    // Loss just short of 70 steps raises nothing; alarm lands about 1402 clocks in
    mains_present_in <= 1'b0;
    cyc(1390);
    check({31'h0, mains_alarm}, 32'h0);
    check({31'h0, undervoltage_trip}, 32'h0);
    cyc(20);
    check({31'h0, mains_alarm}, 32'h1);
    check({31'h0, undervoltage_trip}, 32'h1);
    check({31'h0, error_counter_clear}, 32'h1);
    // Trip deselected: the main-power-off selection takes over, counter held
    axi_wr(OFS_MAINS_OFF, 32'h7, 2'h0);
    axi_wr(OFS_UV_ACTION, 32'h0, 2'h0);
    cyc(4);
    check({31'h0, undervoltage_trip}, 32'h0);
    check({30'h0, brake_action}, {30'h0, dec_of(4'h7, 1'b0)});
    check({31'h0, error_counter_clear}, 32'h0);
    mains_present_in <= 1'b1;
    cyc(8);
    $display("test range and hold time done");
    for (i = 0; i < 10; i++) begin
      axi_wr(OFS_SERVO_OFF, 32'(i), 2'h0);
      servo_on_in <= 1'b0;
      stop_run(dec_of(4'(i), 1'b0), aft_of(4'(i)), !(i >= 4 && i <= 7));
      servo_on_in <= 1'b1;
      cyc(8);
    end
    $display("test servo off done");
    old_b = BRAKE_DYN;
    for (i = 0; i < 3; i++) begin
      axi_wr(OFS_DRIVE_INHIBIT, 32'(i), 2'h0);
      prohibit(1'b1, old_b);
      axi_wr(OFS_CONTROL, 32'h1, 2'h0);
      prohibit(i[0], pro_tab[i]);
      old_b = pro_tab[i];
    end
    $display("test drive prohibit done");
    quick <= 1'b1;
    for (i = 0; i < 16; i++) begin
      e = i % 2;
      axi_wr(OFS_ALARM_STOP, 32'(i / 2), 2'h0);
      alarm_in <= 1'b1;
      alarm_estop_in <= e[0];
      stop_run(dec_of(4'(i / 2), i >= 8 && e == 1), aft_of(4'(i / 2)), 1'b1);
      alarm_in <= 1'b0;
      alarm_estop_in <= 1'b0;
      cyc(8);
    end
    $display("test alarm stop done");
    stop_test();
  end
endmodule
`default_nettype wire
